//--- conv_pkg.sv
// Shared constants and types for the conversion result and status block
package conv_pkg;

    // ------------------------------------------------------------
    // Register indices, decoded on address lines 4..1
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_INT_ENABLE = 4'h9;
    localparam logic [3:0] IDX_EVENT_FLAGS = 4'hA;
    localparam logic [3:0] IDX_TIMER_PRESET = 4'hB;
    localparam logic [3:0] IDX_RESULT_QUEUE = 4'hC;
    localparam logic [3:0] IDX_THRESHOLD_HITS = 4'hD;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Field positions of the flag and enable registers
    // ------------------------------------------------------------
    localparam int FLAG_LIMIT = 0;
    localparam int FLAG_INSTR = 1;
    localparam int FLAG_FIFO = 2;
    localparam int FLAG_CAL_SHORT = 3;
    localparam int FLAG_CAL_FULL = 4;
    localparam int FLAG_PAUSE = 5;
    localparam int FLAG_STANDBY = 7;
    localparam int ADDR_FIELD_LSB = 8;
    localparam int COUNT_FIELD_LSB = 11;

    // ------------------------------------------------------------
    // Result queue and word format
    // ------------------------------------------------------------
    localparam logic [5:0] FIFO_FULL_COUNT = 6'h20;
    localparam logic [3:0] SHORT_RES_LSBS = 4'hE;
    localparam int SIGN_BIT = 12;
    localparam int TAG_LSB = 13;

    // ------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------
    localparam logic [1:0] TIMER_LEAD_CYCLES = 2'h2;
    localparam logic [4:0] PRESCALE_LAST = 5'h1F;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_b;
        logic rd_b;
        logic wr_b;
        logic bw;
        logic [4:0] addr;
        logic [15:0] data;
    } bus_pins_t;

    localparam bus_pins_t PINS_IDLE = '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, bw: 1'b0,
                                        addr: 5'h00, data: 16'h0000};

    typedef struct packed {
        logic [12:0] data;
        logic [2:0] instr;
    } result_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_READ = 3'b010,
        BUS_WRITE = 3'b100
    } bus_state_t;

endpackage

//--- pair_buffer.sv
// Two-entry result buffer between the converter and the result queue
`timescale 1ns/100ps
module pair_buffer
    import conv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire result_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output result_t out_data
);

    typedef struct packed {
        result_t [1:0] slot;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic in_ready;
    } buf_state_t;

    buf_state_t q;
    buf_state_t d;
    logic push;
    logic pop;

    // Push and pop may happen together; ready is registered for timing
    always_comb begin
        d = q;
        push = in_valid && q.in_ready;
        pop = (q.cnt != 2'h0) && out_ready;
        if (push) begin
            d.slot[q.wp] = in_data;
            d.wp = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
        d.in_ready = (d.cnt != 2'h2);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.in_ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign in_ready = q.in_ready;
    assign out_valid = (q.cnt != 2'h0);
    assign out_data = q.slot[q.rp];

endmodule

//--- conv_status.sv
// Result queue, event and limit flags, interval timer and transfer request
//
// Notes on behaviour
// - Each event flag sets on its condition regardless of its enable bit.
// - Reading the event flag register or a device reset clears set flags.
// - Flag bits: 0 limit event, 1 instruction address reached, 2 queue threshold.
// - Flag bits: 3 short calibration, 4 full calibration, 5 pause, 6 unused, 7 standby exit.
// - Bits 8..10 of the flag register show the running instruction address.
// - Bits 11..15 of the flag register show the queue fill while running.
// - Limit bit n sets when instruction n meets its first limit.
// - Limit bit 8+n for second limit; both bytes clear on read or reset.
// - Interval timer is 16 bits behind a 5-bit prescaler, steps of 32 cycles.
// - Timer preset is read/write, low byte 0..7, high byte 8..15, reloaded per use.
// - With timer enabled and preset N, the wait lasts 32*N+2 cycles.
// - Transfer request rises only when enabled and fill equals the 5-bit threshold.
// - Alert output falls in the same cycle the transfer request rises.
// - Request drops when the queue empties; flag read rearms the next request.
// - Byte bus: low byte first; reading high byte pops and loses the low byte.
// - Results sit in a read-only 32 by 16 bit queue at one address.
// - Data in bits 0..12 with sign in 12; short mode forces 1110 in bits 0..3.
// - Bits 13..15 carry sign copies or instruction address, picked by configuration.
// - The queue threshold event never halts the sequencer.
// - Threshold 31 signals at result 31; a final result still fills entry 32.
// - Word bus decodes address 4..1; byte bus adds address 0 as byte select.
`timescale 1ns/100ps
module conv_status
    import conv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic chip_select_b,
    input wire logic read_b,
    input wire logic write_b,
    input wire logic bus_width_select,
    input wire logic [4:0] addr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_b,
    input wire logic seq_running,
    input wire logic instr_fetch,
    input wire logic [2:0] seq_addr,
    input wire logic limit_evt,
    input wire logic limit_second,
    input wire logic [2:0] limit_instr,
    input wire logic cal_short_done,
    input wire logic cal_full_done,
    input wire logic pause_evt,
    input wire logic standby_exit,
    input wire logic soft_reset,
    input wire logic cfg_short_res,
    input wire logic cfg_tag_mode,
    input wire logic timer_start,
    output logic timer_wait_state,
    input wire logic conv_valid,
    output logic conv_ready,
    input wire result_t conv_result,
    output logic transfer_request_out,
    output logic alert_b
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bus_pins_t sync1;
        bus_pins_t sync2;
        bus_state_t bus_st;
        logic [15:0] dout;
        logic oe_b;
        logic [15:0] int_enable;
        logic [7:0] event_flags;
        logic [15:0] threshold_hit_flags;
        logic [15:0] interval_timer_preset;
        logic [1:0] lead;
        logic [15:0] tcnt;
        logic [4:0] presc;
        logic twait;
        logic [31:0][15:0] mem;
        logic [4:0] wp;
        logic [4:0] rp;
        logic [5:0] cnt;
        logic started;
        logic dma;
        logic alert_b;
    } state_t;

    state_t q;
    state_t d;

    bus_pins_t pins;
    logic buf_valid;
    logic buf_ready;
    result_t buf_data;

    logic rd_now;
    logic wr_now;
    logic rd_start;
    logic wr_start;
    logic [3:0] idx;
    logic byte_bus;
    logic byte_select_line;
    logic last_byte;
    logic [15:0] status_word;
    logic [15:0] rd_word;
    logic [15:0] new_word;
    logic [4:0] fill_view;
    logic [4:0] threshold;
    logic full;
    logic empty;
    logic pop;
    logic push_ok;
    logic fifo_read_active;
    logic thr_hit;
    logic clr_events;
    logic clr_limits;
    logic [7:0] set_events;
    logic [15:0] set_limits;

    // Merge a bus write into a register, honouring the byte lane on the byte bus
    function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [15:0] wdat,
                                                input logic bytewide, input logic upper);
        logic [15:0] res;
        res = wdat;
        if (bytewide) begin
            res = upper ? {wdat[7:0], old[7:0]} : {old[15:8], wdat[7:0]};
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Input buffer in front of the result queue
    // ------------------------------------------------------------
    pair_buffer pair_buffer_i (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .in_data(conv_result),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // Pins gathered for the two-stage synchroniser
    always_comb begin
        pins.cs_b = chip_select_b;
        pins.rd_b = read_b;
        pins.wr_b = write_b;
        pins.bw = bus_width_select;
        pins.addr = addr;
        pins.data = data_in;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;

        // Bus pins come from outside the clock domain; only sync2 is used
        d.sync1 = pins;
        d.sync2 = q.sync1;
        rd_now = !q.sync2.cs_b && !q.sync2.rd_b;
        wr_now = !q.sync2.cs_b && !q.sync2.wr_b;
        idx = q.sync2.addr[4:1];
        byte_bus = q.sync2.bw;
        byte_select_line = q.sync2.addr[0];
        last_byte = !byte_bus || byte_select_line;

        // One access per strobe; the strobe must return high before the next
        rd_start = 1'b0;
        wr_start = 1'b0;
        case (q.bus_st)
            BUS_IDLE: begin
                if (rd_now) begin
                    d.bus_st = BUS_READ;
                    rd_start = 1'b1;
                end else if (wr_now) begin
                    d.bus_st = BUS_WRITE;
                    wr_start = 1'b1;
                end
            end
            BUS_READ: begin
                if (!rd_now) begin
                    d.bus_st = BUS_IDLE;
                end
            end
            BUS_WRITE: begin
                if (!wr_now) begin
                    d.bus_st = BUS_IDLE;
                end
            end
            default: begin
                d.bus_st = BUS_IDLE;
            end
        endcase
        d.oe_b = (d.bus_st != BUS_READ);

        // Queue bookkeeping
        full = (q.cnt == FIFO_FULL_COUNT);
        empty = (q.cnt == 6'h00);
        threshold = q.int_enable[15:COUNT_FIELD_LSB];
        // A 32-deep queue does not fit five bits; the view saturates at 31
        fill_view = q.cnt[5] ? 5'h1F : q.cnt[4:0];

        // Live fields only while the sequencer runs
        status_word = {8'h00, q.event_flags};
        if (seq_running) begin
            status_word[15:COUNT_FIELD_LSB] = fill_view;
            status_word[COUNT_FIELD_LSB-1:ADDR_FIELD_LSB] = seq_addr;
        end

        // Read mux; unmapped indices read as zero
        case (idx)
            IDX_INT_ENABLE: rd_word = q.int_enable;
            IDX_EVENT_FLAGS: rd_word = status_word;
            IDX_TIMER_PRESET: rd_word = q.interval_timer_preset;
            IDX_RESULT_QUEUE: rd_word = empty ? REG_RESET : q.mem[q.rp];
            IDX_THRESHOLD_HITS: rd_word = q.threshold_hit_flags;
            default: rd_word = REG_RESET;
        endcase

        // Data is captured once at the start of the read and held
        if (rd_start) begin
            if (!byte_bus) begin
                d.dout = rd_word;
            end else if (byte_select_line) begin
                d.dout = {8'h00, rd_word[15:8]};
            end else begin
                d.dout = {8'h00, rd_word[7:0]};
            end
        end

        // Upper-byte read pops even without the lower read, dropping that byte
        pop = rd_start && (idx == IDX_RESULT_QUEUE) && last_byte && !empty;
        clr_events = rd_start && (idx == IDX_EVENT_FLAGS) && last_byte;
        clr_limits = rd_start && (idx == IDX_THRESHOLD_HITS) && last_byte;

        // Register writes; flag and queue registers ignore writes
        if (wr_start && (idx == IDX_INT_ENABLE)) begin
            d.int_enable = merge_write(q.int_enable, q.sync2.data, byte_bus, byte_select_line);
        end
        if (wr_start && (idx == IDX_TIMER_PRESET)) begin
            d.interval_timer_preset = merge_write(q.interval_timer_preset, q.sync2.data,
                                                  byte_bus, byte_select_line);
        end

        // Wait for room instead of dropping when a queue read is under way
        fifo_read_active = (idx == IDX_RESULT_QUEUE) && ((q.bus_st == BUS_READ) || rd_now);
        buf_ready = !(full && fifo_read_active);
        push_ok = buf_valid && buf_ready && (!full || pop);

        // Word format applied on entry
        new_word = {{3{buf_data.data[SIGN_BIT]}}, buf_data.data};
        if (cfg_short_res) begin
            new_word[3:0] = SHORT_RES_LSBS;
        end
        if (cfg_tag_mode) begin
            new_word[15:TAG_LSB] = buf_data.instr;
        end
        if (push_ok) begin
            d.mem[q.wp] = new_word;
            d.wp = 5'(q.wp + 5'h01);
        end
        if (pop) begin
            d.rp = 5'(q.rp + 5'h01);
        end
        d.cnt = 6'(q.cnt + {5'h00, push_ok} - {5'h00, pop});

        // Threshold hit only on an arriving result; threshold 31 still leaves entry 32
        thr_hit = push_ok && (threshold != 5'h00) && (d.cnt == {1'b0, threshold});

        // The first fetch after a start is not an address-reached event if it is at address 0
        d.started = seq_running && (q.started || instr_fetch);

        // Events set whatever the enable bits say
        set_events = 8'h00;
        set_events[FLAG_LIMIT] = limit_evt;
        set_events[FLAG_INSTR] = instr_fetch && (seq_addr == q.int_enable[COUNT_FIELD_LSB-1:ADDR_FIELD_LSB])
                                 && (q.started || (seq_addr != 3'h0));
        set_events[FLAG_FIFO] = thr_hit;
        set_events[FLAG_CAL_SHORT] = cal_short_done;
        set_events[FLAG_CAL_FULL] = cal_full_done;
        set_events[FLAG_PAUSE] = pause_evt;
        set_events[FLAG_STANDBY] = standby_exit;

        set_limits = limit_evt ? (16'h0001 << {limit_second, limit_instr}) : REG_RESET;

        // A new event in the clearing cycle survives the read
        if (soft_reset) begin
            d.event_flags = 8'h00;
            d.threshold_hit_flags = REG_RESET;
        end else begin
            d.event_flags = (clr_events ? 8'h00 : q.event_flags) | set_events;
            d.threshold_hit_flags = (clr_limits ? REG_RESET : q.threshold_hit_flags) | set_limits;
        end

        // Request needs the enable and a flag cleared since the last request
        if (thr_hit && q.int_enable[FLAG_FIFO] && !q.event_flags[FLAG_FIFO]) begin
            d.dma = 1'b1;
        end else if (d.cnt == 6'h00) begin
            d.dma = 1'b0;
        end

        // Alert from the next flags so it falls on the same edge as the request
        d.alert_b = ~|(d.event_flags & d.int_enable[7:0]);

        // Interval timer: two lead cycles, then N prescaler rounds of 32
        if (timer_start && !q.twait) begin
            d.lead = TIMER_LEAD_CYCLES;
            d.tcnt = q.interval_timer_preset;
            d.presc = 5'h00;
        end else if (q.lead != 2'h0) begin
            d.lead = 2'(q.lead - 2'h1);
        end else if (q.tcnt != 16'h0000) begin
            d.presc = 5'(q.presc + 5'h01);
            if (q.presc == PRESCALE_LAST) begin
                d.tcnt = 16'(q.tcnt - 16'h0001);
            end
        end
        d.twait = (d.lead != 2'h0) || (d.tcnt != 16'h0000);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Pin stages reset to idle levels so no phantom access follows reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.sync1 <= PINS_IDLE;
            q.sync2 <= PINS_IDLE;
            q.bus_st <= BUS_IDLE;
            q.oe_b <= 1'b1;
            q.alert_b <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign data_out = q.dout;
    assign data_oe_b = q.oe_b;
    assign timer_wait_state = q.twait;
    assign transfer_request_out = q.dma;
    assign alert_b = q.alert_b;

endmodule

//--- conv_status_assertions.sv
// Port checks for the result queue and status block
`timescale 1ns/100ps
module conv_status_assertions
    import conv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic chip_select_b,
    input wire logic read_b,
    input wire logic [15:0] data_out,
    input wire logic data_oe_b,
    input wire logic timer_start,
    input wire logic timer_wait_state,
    input wire logic conv_valid,
    input wire logic conv_ready,
    input wire logic transfer_request_out,
    input wire logic alert_b
);
    // Wait length modulo 32 shows the two lead cycles
    logic [4:0] run_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 5'h00;
        end else begin
            run_q <= timer_wait_state ? run_q + 5'h01 : 5'h00;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // --------
    // Transfer request, timer and read port checks
    // --------
    dma_alert_a: assert property ($rose(transfer_request_out) |-> !alert_b)
        else $error("alert high at request");
    dma_cause_a: assert property ($rose(transfer_request_out) |-> $past(conv_valid && conv_ready) ||
        $past(conv_valid && conv_ready, 2)) else $error("request without push");
    timer_step_a: assert property ($fell(timer_wait_state) |-> run_q == 5'h02)
        else $error("timer wait not 32 steps plus 2");
    timer_start_a: assert property (timer_start && !timer_wait_state |=> timer_wait_state)
        else $error("timer start ignored");
    timer_cause_a: assert property ($rose(timer_wait_state) |-> $past(timer_start))
        else $error("timer wait without start");
    oe_cause_a: assert property ($fell(data_oe_b) |-> $past(!chip_select_b && !read_b, 2))
        else $error("drive without read");
    oe_release_a: assert property ($rose(read_b) |-> ##[1:5] data_oe_b)
        else $error("drive after read");
    oe_hold_a: assert property (!data_oe_b && $past(!data_oe_b) |-> $stable(data_out))
        else $error("read data changed while driven");
endmodule

//--- host_bus_model.sv
// Host processor model on the parallel register bus
`timescale 1ns/100ps
module host_bus_model
    import conv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [15:0] data_out,
    input wire logic data_oe_b,
    output bus_pins_t pins
);
    int slow = 0;
    initial pins = PINS_IDLE;

    // Read strobe held until data is driven, write strobe for four cycles, each then held slow more cycles; released data lines show the inverse
    task automatic access(input logic wr, input logic bw, input logic [4:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        int n;
        @(posedge sys_clk);
        #1;
        pins = '{cs_b: 1'b0, rd_b: wr, wr_b: !wr, bw: bw, addr: a, data: wr ? d : ~pins.data};
        for (n = 0; (wr ? n < 4 : data_oe_b !== 1'b0) && n < 20; n++) begin
            @(posedge sys_clk);
            #1;
        end
        q = data_out;
        repeat (slow) begin
            @(posedge sys_clk);
            #1;
        end
        pins = '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, bw: bw, addr: a, data: ~pins.data};
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic rd(input logic [4:0] a, input logic bw, output logic [15:0] q);
        access(1'b0, bw, a, 16'h0000, q);
    endtask

    task automatic wr(input logic [3:0] i, input logic [15:0] d);
        logic [15:0] q;
        access(1'b1, 1'b0, {i, 1'b0}, d, q);
    endtask

    // Threshold zero is never programmed
    task automatic arm(input logic [4:0] thr);
        if (thr != 5'h00) begin
            wr(IDX_INT_ENABLE, {thr, 3'h0, 8'h04});
        end
    endtask

    // Fill checked before each pop; the flag read rearms
    task automatic pop(output logic [15:0] q);
        rd({IDX_EVENT_FLAGS, 1'b0}, 1'b0, q);
        if (q[15:11] != 5'h00) begin
            rd({IDX_RESULT_QUEUE, 1'b0}, 1'b0, q);
        end else begin
            q = 16'h0000;
        end
    endtask
endmodule

//--- conv_status_bench.sv
// Self-checking bench for the result queue and status block
`timescale 1ns/100ps
bind conv_status conv_status_assertions conv_status_assertions_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .chip_select_b(chip_select_b), .read_b(read_b), .data_out(data_out), .data_oe_b(data_oe_b),
    .timer_start(timer_start), .timer_wait_state(timer_wait_state), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .transfer_request_out(transfer_request_out), .alert_b(alert_b));

module conv_status_bench
    import conv_pkg::*;
;
    logic sys_clk;
    logic rst_b;
    logic [7:0] evt;
    logic seq_running, limit_second, cfg_short_res, cfg_tag_mode, conv_valid;
    logic [2:0] seq_addr, limit_instr;
    result_t conv_result;
    bus_pins_t pins;
    logic [15:0] data_out, q;
    logic data_oe_b, timer_wait_state, conv_ready, transfer_request_out, alert_b;
    int err_total = 0;
    int check_count = 0;

    conv_status conv_status_i (.sys_clk(sys_clk), .rst_b(rst_b), .chip_select_b(pins.cs_b),
        .read_b(pins.rd_b), .write_b(pins.wr_b), .bus_width_select(pins.bw), .addr(pins.addr),
        .data_in(pins.data), .data_out(data_out), .data_oe_b(data_oe_b), .seq_running(seq_running),
        .instr_fetch(evt[6]), .seq_addr(seq_addr), .limit_evt(evt[0]), .limit_second(limit_second),
        .limit_instr(limit_instr), .cal_short_done(evt[1]), .cal_full_done(evt[2]), .pause_evt(evt[3]),
        .standby_exit(evt[4]), .soft_reset(evt[7]), .cfg_short_res(cfg_short_res),
        .cfg_tag_mode(cfg_tag_mode), .timer_start(evt[5]), .timer_wait_state(timer_wait_state),
        .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_result(conv_result),
        .transfer_request_out(transfer_request_out), .alert_b(alert_b));

    host_bus_model host_bus_model_i (.sys_clk(sys_clk), .data_out(data_out), .data_oe_b(data_oe_b),
        .pins(pins));

    // --------
    // Shared helpers
    // --------
    task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic rd(input logic [3:0] i, input logic b, input logic h, input logic [15:0] e, input string s);
        host_bus_model_i.rd({i, h}, b, q);
        check(s, e, q);
    endtask

    task automatic rf(input logic [15:0] e, input string s);
        rd(IDX_EVENT_FLAGS, 1'b0, 1'b0, e, s);
    endtask

    // One-cycle pulse on the chosen event lines
    task automatic pulse(input logic [7:0] m);
        @(posedge sys_clk);
        #1 evt = m;
        @(posedge sys_clk);
        #1 evt = 8'h00;
    endtask

    // Valid held until ready at an edge
    task automatic push(input logic [12:0] d, input logic [2:0] ia);
        logic rdy;
        int n;
        @(posedge sys_clk);
        #1;
        conv_valid = 1'b1;
        conv_result = '{data: d, instr: ia};
        n = 0;
        do begin
            rdy = conv_ready;
            @(posedge sys_clk);
            #1;
            n++;
        end while (!rdy && n < 20);
        conv_valid = 1'b0;
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_regs;
        int n;
        rf(REG_RESET, "flags");
        rd(IDX_TIMER_PRESET, 1'b0, 1'b0, REG_RESET, "preset");
        host_bus_model_i.wr(IDX_RESULT_QUEUE, 16'h5555);
        rd(IDX_RESULT_QUEUE, 1'b0, 1'b0, 16'h0000, "queue");
        rd(4'hF, 1'b0, 1'b0, 16'h0000, "unmapped");
        host_bus_model_i.wr(IDX_TIMER_PRESET, 16'h1234);
        rd(IDX_TIMER_PRESET, 1'b1, 1'b0, 16'h0034, "preset_lo");
        rd(IDX_TIMER_PRESET, 1'b1, 1'b1, 16'h0012, "preset_hi");
        host_bus_model_i.wr(IDX_TIMER_PRESET, 16'h0002);
        // Twice, so the preset must reload
        repeat (2) begin
            pulse(8'h20);
            for (n = 0; timer_wait_state === 1'b1 && n < 200; n++) begin
                @(posedge sys_clk);
                #1;
            end
            check("timer_wait", 16'(32 * 2 + 2), 16'(n));
        end
    endtask

    task automatic t_flags;
        pulse(8'h1F);
        rf(16'h00B9, "flags_set");
        rf(16'h0000, "flags_clr");
        limit_instr = 3'h3;
        pulse(8'h01);
        limit_instr = 3'h6;
        limit_second = 1'b1;
        pulse(8'h01);
        rd(IDX_THRESHOLD_HITS, 1'b0, 1'b0, 16'h4009, "limits");
        rd(IDX_THRESHOLD_HITS, 1'b0, 1'b0, 16'h0000, "limits_clr");
        host_bus_model_i.wr(IDX_INT_ENABLE, 16'h0300);
        rf(16'h0001, "flags_pre");
        seq_running = 1'b1;
        seq_addr = 3'h3;
        pulse(8'h40);
        rf(16'h0302, "instr_hit");
        pulse(8'h88);
        rf(16'h0300, "soft_reset");
    endtask

    task automatic t_queue;
        cfg_tag_mode = 1'b1;
        host_bus_model_i.arm(5'h03);
        rf(16'h0300, "flags_arm");
        push(13'h1ABC, 3'h5);
        push(13'h0123, 3'h2);
        check("dma_early", 16'h0000, 16'(transfer_request_out));
        push(13'h0F0F, 3'h7);
        repeat (2) @(posedge sys_clk);
        #1;
        check("dma_rise", 16'h0001, 16'(transfer_request_out));
        check("alert", 16'h0000, 16'(alert_b));
        rf(16'h1B04, "fill");
        rd(IDX_RESULT_QUEUE, 1'b0, 1'b0, 16'hBABC, "word0");
        rd(IDX_RESULT_QUEUE, 1'b0, 1'b0, 16'h4123, "word1");
        rd(IDX_RESULT_QUEUE, 1'b0, 1'b0, 16'hEF0F, "word2");
        check("dma_drop", 16'h0000, 16'(transfer_request_out));
        // Byte bus, sign copies, short words, slow host
        cfg_tag_mode = 1'b0;
        cfg_short_res = 1'b1;
        host_bus_model_i.slow = 2;
        push(13'h1F05, 3'h1);
        rd(IDX_RESULT_QUEUE, 1'b1, 1'b0, 16'h000E, "byte_lo");
        rd(IDX_RESULT_QUEUE, 1'b1, 1'b1, 16'h00FF, "byte_hi");
        push(13'h0055, 3'h0);
        push(13'h0166, 3'h0);
        rd(IDX_RESULT_QUEUE, 1'b1, 1'b1, 16'h0000, "hi_first");
        rd(IDX_RESULT_QUEUE, 1'b1, 1'b0, 16'h006E, "lo_lost");
        rd(IDX_RESULT_QUEUE, 1'b1, 1'b1, 16'h0001, "hi_last");
        host_bus_model_i.slow = 0;
        cfg_tag_mode = 1'b1;
        cfg_short_res = 1'b0;
    endtask

    task automatic t_full;
        host_bus_model_i.arm(5'h1F);
        rf(16'h0300, "flags_arm");
        for (int i = 0; i < 31; i++) begin
            push(13'(i), 3'(i));
        end
        repeat (2) @(posedge sys_clk);
        #1;
        check("dma_31", 16'h0001, 16'(transfer_request_out));
        push(13'h001F, 3'h7);
        push(13'h0AAA, 3'h2);
        rf(16'hFB04, "fill_full");
        for (int i = 0; i < 32; i++) begin
            host_bus_model_i.pop(q);
            check("drain", {3'(i), 13'(i)}, q);
        end
        rd(IDX_RESULT_QUEUE, 1'b0, 1'b0, 16'h0000, "dropped");
        check("dma_empty", 16'h0000, 16'(transfer_request_out));
    endtask

    // --------
    // Verdict, clock, watchdog and main sequence
    // --------
    task automatic report_and_stop;
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // About a thousand cycles expected; wide margin
    initial begin
        #(20000 * 100);
        err_total++;
        report_and_stop;
    end

    initial begin
        rst_b = 1'b0;
        {evt, seq_running, limit_second, cfg_short_res, cfg_tag_mode, conv_valid} = '0;
        {seq_addr, limit_instr} = '0;
        conv_result = '0;
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        t_regs;
        t_flags;
        t_queue;
        t_full;
        report_and_stop;
    end
endmodule
